/* File: rtl/bcsl_pkg.sv */
// Package: offsets, field positions, reset values and timing for the slot/link/product-data bank
package bcsl_pkg;

  // Register byte offsets inside configuration space
  localparam logic [7:0]  OFS_SLOT_STATUS = 8'hC8;
  localparam logic [7:0]  OFS_PHY_CFG0    = 8'hCC;
  localparam logic [7:0]  OFS_PHY_CFG1    = 8'hD0;
  localparam logic [7:0]  OFS_PHY_CFG2    = 8'hD4;
  localparam logic [7:0]  OFS_PD_CONTROL  = 8'hD8;
  localparam logic [7:0]  OFS_PD_DATA     = 8'hDC;

  // Slot status field position (seven flags from bit 16)
  localparam int          SLOT_LSB        = 16;
  localparam int          SLOT_LATCH_CHG  = 2;      // Index inside the seven flags
  localparam int          SLOT_LATCH_ST   = 5;

  // First link register: reset value and writable bits
  localparam logic [31:0] PHY_CFG0_RESET  = 32'h0400_1060;
  localparam logic [31:0] PHY_CFG0_WMASK  = 32'hFFFF_1FFF;
  // Second link register
  localparam logic [31:0] PHY_CFG1_RESET  = 32'h0400_0271;
  localparam logic [31:0] PHY_CFG1_WMASK  = 32'hFFFF_03FF;
  // Third link register, low 24 bits (clock recovery 54h, exit latencies 2h and 19h)
  localparam logic [23:0] PHY_CFG2_RESET  = 24'h19_0254;
  localparam logic [23:0] PHY_CFG2_WMASK  = 24'h7F_7FFF;
  localparam logic [7:0]  DEBOUNCE_RESET  = 8'h00;

  // Product-data capability header
  localparam logic [7:0]  PD_CAP_ID       = 8'h03;
  localparam logic [7:0]  PD_NEXT_CAP     = 8'hF0;
  localparam int          PD_ADDR_LSB     = 18;
  localparam int          PD_OP_BIT       = 31;
  localparam logic [7:0]  PD_EEPROM_BASE  = 8'h40;

  // One millisecond time base at a 40 ns clock
  localparam int          CLK_PERIOD_NS   = 40;
  localparam int          MS_TIME_NS      = 1000000;
  localparam int          MS_CYCLES       = MS_TIME_NS / CLK_PERIOD_NS;

  // Product-data cycle sequencer
  typedef enum logic [2:0]
  {
    PD_IDLE  = 3'b001,
    PD_READ  = 3'b010,
    PD_WRITE = 3'b100
  } bcsl_pd_e;

endpackage : bcsl_pkg

/* File: rtl/bcsl_debounce.sv */
// Hot-swap switch debouncer with a millisecond time base
`timescale 1ns/100ps
module bcsl_debounce #(
  parameter int MS_CYCLES = bcsl_pkg::MS_CYCLES
) (
  input  wire logic       clock,
  input  wire logic       rstN,
  input  wire logic       rawLevel,
  input  wire logic [7:0] limitMs,
  output logic            stable,
  output logic            changed
);

  localparam int TW = $clog2(MS_CYCLES + 1);

  // Tick counter must span at least two cycles
  if (MS_CYCLES < 2)
  begin : g_chk
    $error("MS_CYCLES too small");
  end

  typedef struct packed {
    logic [TW-1:0] tick;    // Cycles inside the current millisecond
    logic [8:0]    msCount; // Whole milliseconds the new level has held
    logic          level;   // Accepted switch level
    logic          pulse;   // One-cycle change report
  } bcsl_dbn_s;

  bcsl_dbn_s st;
  bcsl_dbn_s next_st;

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb
  begin
    next_st       = st;
    next_st.pulse = 1'b0;
    if (rawLevel == st.level)
    begin
      // Any bounce back restarts the whole wait
      next_st.tick    = '0;
      next_st.msCount = '0;
    end
    else if (st.tick == TW'(MS_CYCLES - 1))
    begin
      next_st.tick    = '0;
      next_st.msCount = st.msCount + 9'h001;
      if (st.msCount == {1'b0, limitMs})
      begin
        next_st.level   = rawLevel;
        next_st.pulse   = 1'b1;
        next_st.msCount = '0;
      end
    end
    else
    begin
      next_st.tick = st.tick + TW'(1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge clock or negedge rstN)
  begin
    if (!rstN)
      st <= '0;
    else
      st <= next_st;
  end

  assign stable  = st.level;
  assign changed = st.pulse;

endmodule : bcsl_debounce

/* File: rtl/bcsl_regs.sv */
// Configuration bank: slot status, link tuning, switch debounce and product-data capability
`timescale 1ns/100ps
// Functional notes
// - Seven slot flags in bits 16-22, reset zero
// - Link register zero: enables, counts, L1 timer
// - Link register one resets to 04000271h
// - Clock recovery counted in FTS sets, 54h
// - Debounce field writable only with hot swap
// - Debounce time is field plus one ms
// - Product_data_cap_id 03h, next pointer F0h
// - Operation bit zero starts EEPROM read
// - Read holds bit zero, then sets one
// - Operation bit one starts EEPROM write
// - Write holds bit one, then clears
// - Data LSB is addressed byte, EEPROM +40h
module bcsl_regs #(
  parameter int MS_CYCLES = bcsl_pkg::MS_CYCLES
) (
  input  wire logic        clock,
  input  wire logic        nrst,
  // Configuration access port
  input  wire logic [7:0]  cfgAddr,
  input  wire logic        cfgRead,
  input  wire logic        cfgWrite,
  input  wire logic [3:0]  cfgByteEn,
  input  wire logic [31:0] cfgWdata,
  output logic [31:0]      cfgRdata,
  output logic             cfgRvalid,
  // Hot-plug status sources
  input  wire logic        hotSwapEnable,
  input  wire logic        hotSwapSwitch,
  input  wire logic        slotButton,
  input  wire logic        slotPowerFault,
  input  wire logic        slotPresenceChanged,
  input  wire logic        slotCmdDone,
  input  wire logic        slotPresence,
  // Tuning words toward the link state machine
  output logic [31:0]      phyCfg0,
  output logic [31:0]      phyCfg1,
  output logic [23:0]      phyCfg2,
  // EEPROM cycle port
  output logic             eeReq,
  output logic             eeWrite,
  output logic [7:0]       eeAddr,
  output logic [31:0]      eeWdata,
  input  wire logic        eeDone,
  input  wire logic [31:0] eeRdata
);

  typedef struct packed {
    logic [31:0]        rdata;    // Registered read answer
    logic               rvalid;   // Read answer strobe
    logic [6:0]         slot;     // Slot status flags
    logic [31:0]        cfg0;     // Link register zero
    logic [31:0]        cfg1;     // Link register one
    logic [23:0]        cfg2;     // Link register two
    logic [7:0]         dbnc;     // Switch debounce setting
    logic [5:0]         pdAddr;   // Product-data word address
    logic               pdOp;     // Direction and completion flag
    bcsl_pkg::bcsl_pd_e pdState;  // Cycle sequencer
    logic [31:0]        pdData;   // Product-data data word
    logic               eeReq;    // Cycle start pulse
    logic               eeWrite;  // Cycle direction
    logic [7:0]         eeAddr;   // EEPROM byte address
  } bcsl_regs_s;

  bcsl_regs_s st;
  bcsl_regs_s next_st;
  logic       rstSync1;           // First reset synchroniser stage
  logic       rstN;               // Released reset for the whole block
  logic       swStable;           // Debounced switch level
  logic       swChanged;          // Debounced change pulse
  logic [7:0] wordAddr;           // Access address, word aligned
  logic       wrHit;              // Write strobe

  ////////////////////////////////////////////////////////////////////////////
  // Reset release through two flops
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      rstSync1 <= 1'b0;
      rstN     <= 1'b0;
    end
    else
    begin
      rstSync1 <= 1'b1;
      rstN     <= rstSync1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Switch debouncer, paced by the debounce setting
  bcsl_debounce #(
    .MS_CYCLES (MS_CYCLES)
  ) u_debounce (
    .clock     (clock),
    .rstN      (rstN),
    .rawLevel  (hotSwapSwitch),
    .limitMs   (st.dbnc),
    .stable    (swStable),
    .changed   (swChanged)
  );

  // Byte-lane merge of a write under a writable-bit mask
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] be, input logic [31:0] mask);
    logic [31:0] lanes;
    lanes = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & mask;
    return (old & ~lanes) | (wd & lanes);
  endfunction : merge

  assign wordAddr = {cfgAddr[7:2], 2'b00};
  assign wrHit    = cfgWrite;

  ////////////////////////////////////////////////////////////////////////////
  // Next state: register writes, reads and the EEPROM sequencer
  always_comb
  begin
    next_st        = st;
    next_st.rvalid = 1'b0;
    next_st.eeReq  = 1'b0;

    next_st.slot[0] = slotButton;
    next_st.slot[1] = slotPowerFault;
    next_st.slot[3] = slotPresenceChanged;
    next_st.slot[4] = slotCmdDone;
    next_st.slot[6] = slotPresence;
    next_st.slot[bcsl_pkg::SLOT_LATCH_ST] = swStable;

    // Writing one clears the latch-changed flag
    if (wrHit && wordAddr == bcsl_pkg::OFS_SLOT_STATUS && cfgByteEn[2] && cfgWdata[18])
      next_st.slot[bcsl_pkg::SLOT_LATCH_CHG] = 1'b0;
    if (swChanged)
      next_st.slot[bcsl_pkg::SLOT_LATCH_CHG] = 1'b1;

    if (wrHit)
    begin
      case (wordAddr)
        bcsl_pkg::OFS_PHY_CFG0:
          next_st.cfg0 = merge(st.cfg0, cfgWdata, cfgByteEn, bcsl_pkg::PHY_CFG0_WMASK);
        bcsl_pkg::OFS_PHY_CFG1:
          next_st.cfg1 = merge(st.cfg1, cfgWdata, cfgByteEn, bcsl_pkg::PHY_CFG1_WMASK);
        bcsl_pkg::OFS_PHY_CFG2:
        begin
          // clock recovery and latencies
          // Upper lane belongs to the debounce field, so only the low 24 bits are kept
          next_st.cfg2 = 24'(merge({8'h00, st.cfg2}, cfgWdata, cfgByteEn,
                                   {8'h00, bcsl_pkg::PHY_CFG2_WMASK}));
          if (hotSwapEnable && cfgByteEn[3])
            next_st.dbnc = cfgWdata[31:24];
        end
        bcsl_pkg::OFS_PD_CONTROL:
        begin
          if (st.pdState == bcsl_pkg::PD_IDLE)
          begin
            if (cfgByteEn[2])
              next_st.pdAddr = cfgWdata[bcsl_pkg::PD_ADDR_LSB +: 6];
            if (cfgByteEn[3])
            begin
              next_st.pdOp    = cfgWdata[bcsl_pkg::PD_OP_BIT];
              next_st.eeReq   = 1'b1;
              next_st.eeWrite = cfgWdata[bcsl_pkg::PD_OP_BIT];
              next_st.eeAddr  = {(cfgByteEn[2] ? cfgWdata[bcsl_pkg::PD_ADDR_LSB +: 6] : st.pdAddr), 2'b00}
                                + bcsl_pkg::PD_EEPROM_BASE;
              next_st.pdState = cfgWdata[bcsl_pkg::PD_OP_BIT] ? bcsl_pkg::PD_WRITE
                                                              : bcsl_pkg::PD_READ;
            end
          end
        end
        bcsl_pkg::OFS_PD_DATA:
          next_st.pdData = merge(st.pdData, cfgWdata, cfgByteEn, 32'hFFFF_FFFF);
        default:
          next_st.cfg0 = st.cfg0; // Unmapped or read-only word: no effect
      endcase
    end

    // Completion of the running EEPROM cycle
    case (st.pdState)
      bcsl_pkg::PD_IDLE:
        next_st.pdState = next_st.pdState;
      bcsl_pkg::PD_READ:
        if (eeDone)
        begin
          next_st.pdOp    = 1'b1;
          next_st.pdData  = eeRdata;
          next_st.pdState = bcsl_pkg::PD_IDLE;
        end
      bcsl_pkg::PD_WRITE:
        if (eeDone)
        begin
          next_st.pdOp    = 1'b0;
          next_st.pdState = bcsl_pkg::PD_IDLE;
        end
      default:
        next_st.pdState = bcsl_pkg::PD_IDLE;
    endcase

    // Read answer one cycle after the request
    if (cfgRead)
    begin
      next_st.rvalid = 1'b1;
      case (wordAddr)
        bcsl_pkg::OFS_SLOT_STATUS: next_st.rdata = {9'h000, st.slot, 16'h0000};
        bcsl_pkg::OFS_PHY_CFG0:    next_st.rdata = st.cfg0;
        bcsl_pkg::OFS_PHY_CFG1:    next_st.rdata = st.cfg1;
        bcsl_pkg::OFS_PHY_CFG2:    next_st.rdata = {st.dbnc, st.cfg2};
        bcsl_pkg::OFS_PD_CONTROL:  next_st.rdata = {st.pdOp, 7'h00, st.pdAddr, 2'b00,
                                                    bcsl_pkg::PD_NEXT_CAP, bcsl_pkg::PD_CAP_ID};
        bcsl_pkg::OFS_PD_DATA:     next_st.rdata = st.pdData;
        default:                   next_st.rdata = 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register with documented reset values
  always_ff @(posedge clock or negedge rstN)
  begin
    if (!rstN)
    begin
      st         <= '0;
      st.cfg0    <= bcsl_pkg::PHY_CFG0_RESET;
      st.cfg1    <= bcsl_pkg::PHY_CFG1_RESET;
      st.cfg2    <= bcsl_pkg::PHY_CFG2_RESET;
      st.dbnc    <= bcsl_pkg::DEBOUNCE_RESET;
      st.pdState <= bcsl_pkg::PD_IDLE;
    end
    else
    begin
      st <= next_st;
    end
  end

  // Outputs straight from state flops
  assign cfgRdata  = st.rdata;
  assign cfgRvalid = st.rvalid;
  assign phyCfg0   = st.cfg0;
  assign phyCfg1   = st.cfg1;
  assign phyCfg2   = st.cfg2;
  assign eeReq     = st.eeReq;
  assign eeWrite   = st.eeWrite;
  assign eeAddr    = st.eeAddr;
  assign eeWdata   = st.pdData;

endmodule : bcsl_regs

/* File: sim/bcsl_regs_props.sv */
// Checker: port-level relations of the configuration bank
`timescale 1ns/100ps
module bcsl_regs_props #(
  parameter int MS_CYCLES = 4
) (
  input wire logic        clock,
  input wire logic        nrst,
  input wire logic [7:0]  cfgAddr,
  input wire logic        cfgRead,
  input wire logic        cfgWrite,
  input wire logic [3:0]  cfgByteEn,
  input wire logic [31:0] cfgWdata,
  input wire logic [31:0] cfgRdata,
  input wire logic        cfgRvalid,
  input wire logic [31:0] phyCfg1,
  input wire logic        eeReq,
  input wire logic        eeWrite,
  input wire logic [7:0]  eeAddr
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  ////////////////////////////////////////////////////////////////////////
  // Read answer comes exactly one cycle after the request
  chk_read_answer: assert property (cfgRead |=> cfgRvalid) else $error("read not answered");
  chk_answer_cause: assert property (cfgRvalid |-> $past(cfgRead)) else $error("stray read answer");
  // Slot status reserved bits 31-23 stay zero
  chk_slot_reserved: assert property (cfgRvalid && $past(cfgAddr[7:2]) == 6'h32 |-> cfgRdata[31:23] == 9'h000)
    else $error("slot reserved bits set");
  // Capability header is constant
  chk_cap_header: assert property (cfgRvalid && $past(cfgAddr[7:2]) == 6'h36 |-> cfgRdata[15:0] == 16'hF003)
    else $error("capability header wrong");
  // EEPROM start only from a top-lane write to the control word
  chk_start_cause: assert property (eeReq |-> $past(cfgWrite && cfgAddr[7:2] == 6'h36 && cfgByteEn[3]))
    else $error("start without control write");
  chk_start_dir: assert property (eeReq |-> eeWrite == $past(cfgWdata[31]))
    else $error("cycle direction wrong");
  // Only a start that also carried the address lane uses the freshly written address
  chk_start_addr: assert property (eeReq && $past(cfgByteEn[2]) |-> eeAddr == {$past(cfgWdata[23:18]), 2'b00} + 8'h40)
    else $error("EEPROM address wrong");
  chk_start_pulse: assert property (eeReq |=> !eeReq) else $error("start longer than a cycle");
  chk_link_reserved: assert property (phyCfg1[15:10] == 6'h00) else $error("link reserved bits set");
endmodule : bcsl_regs_props

bind bcsl_regs bcsl_regs_props #(.MS_CYCLES(MS_CYCLES)) u_props (.clock(clock), .nrst(nrst), .cfgAddr(cfgAddr),
  .cfgRead(cfgRead), .cfgWrite(cfgWrite), .cfgByteEn(cfgByteEn), .cfgWdata(cfgWdata), .cfgRdata(cfgRdata),
  .cfgRvalid(cfgRvalid), .phyCfg1(phyCfg1), .eeReq(eeReq), .eeWrite(eeWrite), .eeAddr(eeAddr));

/* File: sim/bcsl_ee_model.sv */
// Behavioural serial EEPROM: answers each cycle after a fixed latency
`timescale 1ns/100ps
module bcsl_ee_model #(
  parameter int LAT = 12
) (
  input wire logic        clock,
  input wire logic        eeReq,
  input wire logic        eeWrite,
  input wire logic [7:0]  eeAddr,
  input wire logic [31:0] eeWdata,
  output logic            eeDone,
  output logic [31:0]     eeRdata
);
  int          cnt = 0;      // Cycles left in the running cycle
  logic [7:0]  wrAddr = '0;  // Last written address, seen by the bench
  logic [31:0] wrData = '0;  // Last written word
  initial eeDone = 1'b0;
  initial eeRdata = 32'h0;
  ////////////////////////////////////////////////////////////////////////
  // Data is only valid with done; otherwise it toggles so no stale value passes
  always @(posedge clock)
  begin
    eeDone <= 1'b0;
    eeRdata <= ~eeRdata;
    if (eeReq)
      cnt <= LAT;
    else if (cnt != 0)
    begin
      cnt <= cnt - 1;
      if (cnt == 1)
      begin
        eeDone <= 1'b1;
        if (eeWrite)
        begin
          wrAddr <= eeAddr;
          wrData <= eeWdata;
        end
        else
          eeRdata <= {eeAddr, ~eeAddr, eeAddr ^ 8'h5A, eeAddr};
      end
    end
  end
endmodule : bcsl_ee_model

/* File: sim/bridge_cfg_slot_link_vpd_regs_test.sv */
// Testbench of the configuration bank with an EEPROM model
`timescale 1ns/100ps
module bridge_cfg_slot_link_vpd_regs_test;
  logic clock = 0, nrst = 0, cfgRead = 0, cfgWrite = 0, rvalid, eeReq, eeWrite, eeDone;
  logic hotSwapEnable = 0, hotSwapSwitch = 0, button = 0, fault = 0, presChg = 0, cmdDone = 0, presence = 0;
  logic [7:0]  cfgAddr = 0, eeAddr;
  logic [3:0]  cfgByteEn = 0;
  logic [31:0] cfgWdata = 0, cfgRdata, phyCfg0, phyCfg1, eeWdata, eeRdata, d;
  logic [23:0] phyCfg2;
  int errCount = 0, totalChecks = 0;
  initial forever #20 clock = ~clock;
  bcsl_regs #(.MS_CYCLES(4)) dut (.clock(clock), .nrst(nrst), .cfgAddr(cfgAddr), .cfgRead(cfgRead),
    .cfgWrite(cfgWrite), .cfgByteEn(cfgByteEn), .cfgWdata(cfgWdata), .cfgRdata(cfgRdata), .cfgRvalid(rvalid),
    .hotSwapEnable(hotSwapEnable), .hotSwapSwitch(hotSwapSwitch), .slotButton(button), .slotPowerFault(fault),
    .slotPresenceChanged(presChg), .slotCmdDone(cmdDone), .slotPresence(presence), .phyCfg0(phyCfg0),
    .phyCfg1(phyCfg1), .phyCfg2(phyCfg2), .eeReq(eeReq), .eeWrite(eeWrite), .eeAddr(eeAddr),
    .eeWdata(eeWdata), .eeDone(eeDone), .eeRdata(eeRdata));
  bcsl_ee_model u_ee (.clock(clock), .eeReq(eeReq), .eeWrite(eeWrite), .eeAddr(eeAddr), .eeWdata(eeWdata),
    .eeDone(eeDone), .eeRdata(eeRdata));
  ////////////////////////////////////////////////////////////////////////
  // Shared tasks
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    totalChecks++;
    if (s !== e)
    begin
      errCount++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  // One request edge, then one idle edge, so a following call never retoggles a strobe in the same step
  task wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] v);
    cfgAddr = a; cfgByteEn = be; cfgWdata = v; cfgWrite = 1;
    @(posedge clock); #1 cfgWrite = 0;
    @(posedge clock); #1;
  endtask : wr
  // Answer is registered: strobe and data stand in the cycle after the request edge
  task rd(input logic [7:0] a);
    cfgAddr = a; cfgRead = 1;
    @(posedge clock); #1 cfgRead = 0;
    d = cfgRdata;
    chk("read strobe", {31'h0, rvalid}, 32'h1);
    @(posedge clock); #1;
    chk("strobe drop", {31'h0, rvalid}, 32'h0);
  endtask : rd
  // Software waits for the completion value before going on
  task poll(input logic v);
    for (int i = 0; i < 100 && d[31] !== v; i++) rd(8'hD8);
    chk("op bit done", {31'h0, d[31]}, {31'h0, v});
  endtask : poll
  task completeRun;
    $display("checks %0d mismatches %0d", totalChecks, errCount);
    if (errCount == 0 && totalChecks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : completeRun
  ////////////////////////////////////////////////////////////////////////
  // Scenarios
  task t_reset;
    rd(8'hC8); chk("slot rst", d, 32'h0);
    rd(8'hCC); chk("cfg0 rst", d, 32'h0400_1060);
    rd(8'hD0); chk("cfg1 rst", d, 32'h0400_0271);
    rd(8'hD4); chk("cfg2 rst", d, 32'h0019_0254);
    rd(8'hD8); chk("cap rst", d, 32'h0000_F003);
    rd(8'hE0); chk("unmapped", d, 32'h0);
  endtask : t_reset
  task t_masks;
    wr(8'hCC, 4'hF, '1); wr(8'hD0, 4'hF, '1); wr(8'hD4, 4'h7, '1); wr(8'hE0, 4'hF, '1);
    rd(8'hCC); chk("cfg0 mask", d, 32'hFFFF_1FFF);
    chk("cfg0 port", phyCfg0, 32'hFFFF_1FFF);
    chk("cfg1 port", phyCfg1, 32'hFFFF_03FF);
    chk("cfg2 port", {8'h00, phyCfg2}, 32'h007F_7FFF);
    rd(8'hD0); chk("cfg1 mask", d, 32'hFFFF_03FF);
    rd(8'hD4); chk("cfg2 mask", d, 32'h007F_7FFF);
    rd(8'hE0); chk("unmapped wr", d, 32'h0);
  endtask : t_masks
  task t_debounce;
    wr(8'hD4, 4'h8, 32'h0100_0000); rd(8'hD4); chk("field locked", d[31:24], 8'h00);
    hotSwapEnable = 1; wr(8'hD4, 4'h8, 32'h0100_0000);
    hotSwapEnable = 0; wr(8'hD4, 4'h8, 32'hFF00_0000);
    rd(8'hD4); chk("field written", d[31:24], 8'h01);
    // Two ms selected: a read taken 9 edges after the switch moves is one edge too early
    hotSwapSwitch = 1; repeat (8) @(posedge clock); #1 rd(8'hC8);
    chk("early change", d & 32'h0024_0000, 32'h0);
    // The next read lands after the change has been accepted
    rd(8'hC8);
    chk("late change", d & 32'h0024_0000, 32'h0024_0000);
    wr(8'hC8, 4'h4, 32'h0004_0000); rd(8'hC8); chk("clear change", d[18], 1'b0);
  endtask : t_debounce
  task t_slot;
    button = 1; fault = 1; presChg = 1; cmdDone = 1; presence = 1;
    repeat (2) @(posedge clock); #1 rd(8'hC8);
    chk("slot flags", d, 32'h007B_0000);
  endtask : t_slot
  task t_ee;
    wr(8'hD8, 4'hC, 32'h0008_0000); rd(8'hD8);
    chk("read busy", d[31], 1'b0);
    poll(1'b1);
    chk("read dir", {31'h0, eeWrite}, 32'h0);
    chk("read addr", {24'h0, eeAddr}, 32'h0000_0048);
    rd(8'hDC); chk("read data", d, {8'h48, 8'hB7, 8'h12, 8'h48});
    wr(8'hDC, 4'hF, 32'h1234_5678); wr(8'hD8, 4'hC, 32'h8014_0000); rd(8'hD8);
    chk("write busy", d[31], 1'b1);
    poll(1'b0);
    chk("write dir", {31'h0, eeWrite}, 32'h1);
    chk("write addr", u_ee.wrAddr, 8'h54);
    chk("write data", u_ee.wrData, 32'h1234_5678);
  endtask : t_ee
  ////////////////////////////////////////////////////////////////////////
  // Main sequence and watchdog
  initial
  begin
    repeat (5) @(posedge clock);
    #1 nrst = 1;
    repeat (3) @(posedge clock);
    #1 t_reset; t_masks; t_debounce; t_slot; t_ee;
    completeRun;
  end
  initial
  begin
    repeat (3000) @(posedge clock);
    errCount++;
    completeRun;
  end
endmodule : bridge_cfg_slot_link_vpd_regs_test
